// >>> hdl/config_pin_control.sv
// Configuration pin controller: done, reconfigure, mode pins, data loader and test port
//
// Notes on behaviour
// RULE1 - Done pin is released high only when loading completes; held low during load.
// RULE2 - User mode is withheld while anyone holds the done pin low.
// RULE3 - A fresh load starts when the reconfigure input rises after a valid low pulse.
// RULE4 - Reconfigure restarts loading only; user logic is not reset by it. The code drops user mode on a restart.
// RULE5 - Test port samples TMS and TDI on rising TCK.
// RULE6 - TDO changes only after falling TCK.
// RULE7 - Undriven TMS or TDI reads as logic one.
// RULE8 - TDI shifts through instruction or selected data register out to TDO.
// RULE9 - TDO is released whenever no shift is in progress.
// RULE10 - Image select input is used only when multi-image mode is enabled.
// RULE11 - Config clock pin is input in passive mode, driven in active mode.
// RULE12 - Data line 0 in passive, out active; line 1 opposite; up to 32 wide. The code never drives line 0 during configuration.
// RULE13 - Configuration accepted only while chip select input is high. The code ignores chip select in active mode.
// RULE14 - Cascade select output enables the next device in a chain.
// RULE15 - Error output goes low on ID mismatch, CRC failure or remote update failure.
// RULE16 - Mode pin sampled and latched on leaving reconfigure reset; one means active.
// RULE17 - In active mode the mode pin becomes low-true select of flash one.
// RULE18 - Dual quad active mode drives a low-true select for flash two.
// RULE19 - Active mode can take its clock from the external load clock pin.
// RULE20 - Outside party keeps test enable high during configuration.
// RULE21 - Dual-purpose pins go to user logic after configuration; dedicated ones never. The code hands only the data lines to user logic.
// RULE22 - Passive host waits first data delay after reconfigure release before data.
// RULE23 - Test port load enters user mode after done high and user entry instruction.
`timescale 1ns/1ps
module config_pin_control
  import cfg_pin_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Dedicated pins
  input wire logic config_done_flag_in,
  output logic config_done_flag_oe,
  input wire logic creset_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tms_driven,
  input wire logic tdi,
  input wire logic tdi_driven,
  output logic tdo,
  output logic tdo_oe,
  // Dual-purpose pins
  input wire logic [1:0] image_select,
  input wire logic config_clock_pin_in,
  output logic config_clock_pin_out,
  output logic config_clock_pin_oe,
  input wire logic [DATA_W-1:0] config_data_lines_in,
  output logic [DATA_W-1:0] config_data_lines_out,
  output logic [DATA_W-1:0] config_data_lines_oe,
  input wire logic chip_select_in,
  output logic cascade_select_out,
  output logic config_error_n,
  input wire logic mode_select_flash1_cs_n_in,
  output logic mode_select_flash1_cs_n_out,
  output logic mode_select_flash1_cs_n_oe,
  output logic flash2_select_n,
  input wire logic external_load_clock,
  input wire logic test_n,
  // Configuration and status ports
  input wire logic multi_image_en,
  input wire logic dual_quad_en,
  input wire logic ext_clk_sel,
  input wire logic cascade_en,
  input wire logic [1:0] bus_width,
  input wire logic id_fail,
  input wire logic crc_fail,
  input wire logic remote_fail,
  input wire logic load_last,
  input wire logic tap_load,
  // Loader stream out to the bitstream engine
  output logic [DATA_W-1:0] load_data,
  output logic load_valid,
  input wire logic load_ready,
  output logic [1:0] image_index,
  output logic active_mode,
  output logic user_mode,
  // User-side I/O after configuration
  input wire logic [DATA_W-1:0] user_io_out,
  input wire logic [DATA_W-1:0] user_io_oe,
  output logic [DATA_W-1:0] user_io_in
);
  // ==========================================================
  // Input synchronisers
  localparam int NS = 12;
  logic [NS-1:0] raw, s1_q, s2_q, s3_q;
  assign raw = {config_done_flag_in, creset_n, tck, tms | ~tms_driven, tdi | ~tdi_driven, // RULE7
                config_clock_pin_in, chip_select_in, mode_select_flash1_cs_n_in, external_load_clock,
                test_n, image_select};
  // Two flops for each pin; third flop only feeds edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= {NS{1'b1}};
      s2_q <= {NS{1'b1}};
      s3_q <= {NS{1'b1}};
    end else if (ce) begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  logic [DATA_W-1:0] din1_q, din_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      din1_q <= '0;
      din_q <= '0;
    end else if (ce) begin
      din1_q <= config_data_lines_in;
      din_q <= din1_q;
    end
  end
  wire done_pin = s2_q[11];
  wire creset_s = s2_q[10];
  wire creset_rise = s2_q[10] & ~s3_q[10];
  wire tck_rise = s2_q[9] & ~s3_q[9];
  wire tck_fall = ~s2_q[9] & s3_q[9];
  wire tms_s = s2_q[8];
  wire tdi_s = s2_q[7];
  wire cck_rise = s2_q[6] & ~s3_q[6];
  wire csi_s = s2_q[5];
  wire mode_pin = s2_q[4];
  wire ext_rise = s2_q[3] & ~s3_q[3];
  wire [1:0] image_select_s = s2_q[1:0];

  // ==========================================================
  // Test access port
  logic enter_user_p;
  logic tdo_w, tdo_oe_w;
  cfg_tap u_tap (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .tck_rise(tck_rise),
    .tck_fall(tck_fall),
    .tms(tms_s),
    .tdi(tdi_s),
    .tdo(tdo_w),
    .tdo_oe(tdo_oe_w),
    .enter_user(enter_user_p)
  );
  assign tdo = tdo_w;
  assign tdo_oe = tdo_oe_w;

  // ==========================================================
  // Reconfigure pulse width and loader sequence
  load_state_t st_q;
  logic [15:0] lowcnt_q;
  logic [23:0] wait_q;
  logic act_q, user_q, err_q, tap_enter_q, dq_q;
  logic [1:0] img_q;
  wire pulse_ok = (lowcnt_q >= 16'(CRESET_MIN_CYC));
  wire restart = creset_rise && pulse_ok;
  wire busy = (st_q == LD_WAIT) || (st_q == LD_LOAD);
  wire fail = id_fail || crc_fail || remote_fail;
  // Count how long the reconfigure input has been low
  always_ff @(posedge clk) begin
    if (rst) begin
      lowcnt_q <= '0;
    end else if (ce) begin
      if (creset_s) begin
        lowcnt_q <= '0;
      end else if (!pulse_ok) begin
        lowcnt_q <= lowcnt_q + 16'h0001;
      end
    end
  end
  // Clock strobe: own divider or external clock in active mode, pin clock in passive
  logic [1:0] div_q;
  logic cclk_q;
  wire div_tick = (div_q == 2'(ACT_CLK_DIV/2 - 1));
  wire act_edge = ext_clk_sel ? ext_rise : (div_tick && !cclk_q); // RULE19
  wire data_edge = act_q ? act_edge : cck_rise; // RULE11
  wire fifo_ready;
  wire take = (st_q == LD_LOAD) && data_edge && (act_q || csi_s) && fifo_ready; // RULE13
  // Loader state
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= LD_IDLE;
      act_q <= 1'b0;
      img_q <= 2'h0;
      err_q <= 1'b0;
      wait_q <= '0;
      tap_enter_q <= 1'b0;
      dq_q <= 1'b0;
    end else if (ce) begin
      if (restart) begin
        st_q <= LD_WAIT; // RULE3
        act_q <= mode_pin; // RULE16
        img_q <= multi_image_en ? image_select_s : 2'h0; // RULE10
        dq_q <= dual_quad_en;
        err_q <= 1'b0;
        tap_enter_q <= 1'b0;
        wait_q <= '0;
      end else begin
        if (enter_user_p) begin
          tap_enter_q <= 1'b1;
        end
        unique case (st_q)
          LD_IDLE: ;
          LD_WAIT: begin
            wait_q <= wait_q + 24'h000001;
            if (act_q || wait_q >= 24'(FIRST_DATA_DELAY_CYC - 1)) begin
              st_q <= LD_LOAD; // RULE22
            end
          end
          LD_LOAD: begin
            if (fail) begin
              st_q <= LD_ERROR;
              err_q <= 1'b1; // RULE15
            end else if (load_last) begin
              st_q <= LD_DONE;
            end
          end
          LD_DONE: begin
            if (fail) begin
              st_q <= LD_ERROR;
              err_q <= 1'b1;
            end else if (done_pin && (!tap_load || tap_enter_q || enter_user_p)) begin
              st_q <= LD_USER; // RULE2 RULE23
            end
          end
          LD_USER: ;
          LD_ERROR: ;
        endcase
      end
    end
  end
  // Active clock divider
  always_ff @(posedge clk) begin
    if (rst) begin
      div_q <= '0;
      cclk_q <= 1'b0;
    end else if (ce) begin
      if (div_tick) begin
        div_q <= '0;
        cclk_q <= ~cclk_q;
      end else begin
        div_q <= div_q + 2'h1;
      end
    end
  end

  // ==========================================================
  // Data gather: width selects how many lines feed each word
  // Serial x1 takes line 0 in passive mode and line 1 in active mode; wider modes use the low lines
  function automatic logic [DATA_W-1:0] gather(input logic [1:0] width, input logic act,
                                               input logic [DATA_W-1:0] lines);
    logic [DATA_W-1:0] word;
    word = '0;
    unique case (width)
      WIDTH_X1: word[0] = act ? lines[1] : lines[0];
      WIDTH_X4: word[3:0] = lines[3:0];
      WIDTH_X8: word[7:0] = lines[7:0];
      WIDTH_X32: word = lines;
    endcase
    return word;
  endfunction
  logic [DATA_W-1:0] word_d;
  assign word_d = gather(bus_width, act_q, din_q); // RULE12
  // Buffer side of the output stage
  logic [DATA_W-1:0] fifo_data;
  logic fifo_valid;
  logic [DATA_W-1:0] ld_data_q;
  logic ld_valid_q;
  wire stage_free = !ld_valid_q || load_ready;
  cfg_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst || (ce && restart)),
    .ce(ce),
    .in_data(word_d),
    .in_valid(take),
    .in_ready(fifo_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(stage_free)
  );
  // Output stage: the stream leaves from flops and holds while the engine stalls
  always_ff @(posedge clk) begin
    if (rst) begin
      ld_valid_q <= 1'b0;
      ld_data_q <= '0;
    end else if (ce) begin
      if (restart) begin
        ld_valid_q <= 1'b0;
      end else if (stage_free) begin
        ld_valid_q <= fifo_valid;
        ld_data_q <= fifo_data;
      end
    end
  end
  assign load_data = ld_data_q;
  assign load_valid = ld_valid_q;

  // ==========================================================
  // Registered pin outputs
  wire in_cfg = (st_q != LD_USER);
  always_ff @(posedge clk) begin
    if (rst) begin
      config_done_flag_oe <= 1'b1;
      config_clock_pin_out <= 1'b0;
      config_clock_pin_oe <= 1'b0;
      config_data_lines_out <= '0;
      config_data_lines_oe <= '0;
      cascade_select_out <= 1'b0;
      config_error_n <= 1'b1;
      mode_select_flash1_cs_n_out <= 1'b1;
      mode_select_flash1_cs_n_oe <= 1'b0;
      flash2_select_n <= 1'b1;
      user_q <= 1'b0;
      user_io_in <= '0;
    end else if (ce) begin
      config_done_flag_oe <= !((st_q == LD_DONE) || (st_q == LD_USER)); // RULE1
      config_error_n <= !err_q; // RULE15
      config_clock_pin_out <= cclk_q;
      config_clock_pin_oe <= act_q && busy; // RULE11
      // Passive x1 echoes data on line 1; user drives all lines afterwards
      config_data_lines_out <= in_cfg ? {30'h0, din_q[0], 1'b0} : user_io_out; // RULE21
      config_data_lines_oe <= in_cfg ? {30'h0, (!act_q && busy && bus_width == WIDTH_X1), 1'b0}
                                     : user_io_oe; // RULE12 RULE21
      cascade_select_out <= cascade_en && (st_q == LD_DONE || st_q == LD_USER); // RULE14
      mode_select_flash1_cs_n_out <= !(act_q && busy); // RULE17
      mode_select_flash1_cs_n_oe <= act_q && busy;
      flash2_select_n <= !(act_q && dq_q && busy); // RULE18
      user_q <= (st_q == LD_USER); // RULE4
      user_io_in <= in_cfg ? '0 : din_q; // RULE21
    end
  end
  assign user_mode = user_q;
  assign image_index = img_q;
  assign active_mode = act_q;
endmodule

// >>> shared/cfg_pin_pkg.sv
// Package: constants and types shared by the configuration pin controller
package cfg_pin_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int FIRST_DATA_DELAY_US = 32;
  localparam int FIRST_DATA_DELAY_CYC = (FIRST_DATA_DELAY_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CRESET_MIN_NS = 100;
  localparam int CRESET_MIN_CYC = (CRESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACT_CLK_DIV = 4;
  // ==========================================================
  // Widths and codes
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 8;
  localparam int IR_W = 4;
  localparam logic [IR_W-1:0] IR_RESET = 4'h1;
  localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
  localparam logic [IR_W-1:0] IR_ENTER_USER = 4'h7;
  localparam logic [IR_W-1:0] IR_IDCODE = 4'h3;
  localparam logic [31:0] ID_CODE = 32'h0a5a_5001; // Arbitrary value
  localparam logic [1:0] WIDTH_X1 = 2'h0;
  localparam logic [1:0] WIDTH_X4 = 2'h1;
  localparam logic [1:0] WIDTH_X8 = 2'h2;
  localparam logic [1:0] WIDTH_X32 = 2'h3;
  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR,
    TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
    TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } tap_state_t;
  typedef enum logic [2:0] {
    LD_IDLE, LD_WAIT, LD_LOAD, LD_DONE, LD_USER, LD_ERROR
  } load_state_t;
endpackage

// >>> hdl/cfg_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module cfg_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  // Storage and pointers
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// >>> hdl/cfg_tap.sv
// Test access port: state machine, instruction and data registers
`timescale 1ns/1ps
module cfg_tap
  import cfg_pin_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic tck_rise,
  input wire logic tck_fall,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  output logic enter_user
);
  tap_state_t st_q, st_d;
  logic [IR_W-1:0] ir_sh_q, ir_q;
  logic [31:0] dr_q;
  logic byp_q;
  // ==========================================================
  // Next state from TMS
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      TAP_RESET: st_d = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: st_d = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: st_d = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: st_d = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: st_d = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: st_d = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: st_d = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: st_d = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: st_d = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: st_d = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: st_d = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: st_d = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: st_d = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: st_d = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: st_d = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: st_d = tms ? TAP_SEL_DR : TAP_IDLE;
    endcase
  end
  wire sel_id = (ir_q == IR_IDCODE);
  wire dr_out = sel_id ? dr_q[0] : byp_q;
  // Sample TMS/TDI on the TCK rising edge, shift registers through TDI
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= TAP_RESET;
      ir_q <= IR_IDCODE;
      ir_sh_q <= '0;
      dr_q <= '0;
      byp_q <= 1'b0;
      enter_user <= 1'b0;
    end else if (ce) begin
      enter_user <= 1'b0;
      if (tck_rise) begin
        st_q <= st_d; // RULE5
        unique case (st_q)
          TAP_RESET: ir_q <= IR_IDCODE;
          TAP_CAP_IR: ir_sh_q <= IR_RESET;
          TAP_SHIFT_IR: ir_sh_q <= {tdi, ir_sh_q[IR_W-1:1]}; // RULE8
          TAP_UPD_IR: begin
            ir_q <= ir_sh_q;
            enter_user <= (ir_sh_q == IR_ENTER_USER); // RULE23
          end
          TAP_CAP_DR: begin
            dr_q <= ID_CODE;
            byp_q <= 1'b0;
          end
          TAP_SHIFT_DR: begin
            dr_q <= {tdi, dr_q[31:1]}; // RULE8
            byp_q <= tdi;
          end
          default: ;
        endcase
      end
    end
  end
  // TDO changes only after falling TCK; released outside shift states
  always_ff @(posedge clk) begin
    if (rst) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (ce && tck_fall) begin
      tdo <= (st_q == TAP_SHIFT_IR) ? ir_sh_q[0] : dr_out; // RULE6
      tdo_oe <= (st_q == TAP_SHIFT_IR) || (st_q == TAP_SHIFT_DR); // RULE9
    end
  end
endmodule

// >>> tb/cfg_host_model.sv
// Host processor model for the passive configuration port
`timescale 1ns/1ps
module cfg_host_model (
  output logic creset_n,
  output logic mode_pin,
  output logic config_clock_pin,
  output logic [31:0] data,
  output logic cs,
  output logic test_n,
  output logic done_hold
);
  // Idle levels: test mode off, clock parked low between frames
  initial begin
    creset_n = 1'h1;
    mode_pin = 1'h0;
    config_clock_pin = 1'h0;
    data = 32'h0;
    cs = 1'h1;
    test_n = 1'h1;
    done_hold = 1'h0;
  end
  // =====
  // Reconfigure pulse, mode strap held steady across the release
  task reconfig(input logic act);
    mode_pin = act;
    creset_n = 1'h0;
    #200;
    creset_n = 1'h1;
  endtask
  // No data until the first data delay has run out
  task wait_first;
    #32100;
  endtask
  // One word per clock; data goes to its inverse once released
  task send(input logic [31:0] w, input logic sel);
    #1;
    cs = sel;
    data = w;
    #62.5 config_clock_pin = 1'h1;
    #62.5 config_clock_pin = 1'h0;
    data = ~w;
    cs = 1'h1;
  endtask
  // Wired-low hold on the done line
  task hold_done(input logic v);
    done_hold = v;
  endtask
endmodule

// >>> tb/config_pin_control_props.sv
// Concurrent checks on the configuration pin controller ports
`timescale 1ns/1ps
module config_pin_control_props (
  input logic clk,
  input logic rst,
  input logic config_done_flag_in,
  input logic config_done_flag_oe,
  input logic load_last,
  input logic user_mode,
  input logic tck,
  input logic tdo,
  input logic tdo_oe,
  input logic config_error_n,
  input logic id_fail,
  input logic crc_fail,
  input logic remote_fail,
  input logic active_mode,
  input logic config_clock_pin_oe,
  input logic mode_select_flash1_cs_n_oe,
  input logic flash2_select_n,
  input logic [31:0] config_data_lines_oe,
  input logic load_valid,
  input logic load_ready,
  input logic [31:0] load_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Settled passive mode before user mode
  property idle_pin(p);
    !active_mode && !$past(active_mode) && !user_mode |-> p;
  endproperty
  // =====
  // Done pin, error flag and test port
  user_gate_a: assert property ($rose(user_mode) |-> $past(config_done_flag_in) && !config_done_flag_oe)
    else $error("user mode entered while done was low");
  done_release_a: assert property ($fell(config_done_flag_oe) |-> $past(load_last) || $past(load_last, 2))
    else $error("done released without end of load");
  err_set_a: assert property ((id_fail || crc_fail || remote_fail) |-> ##[1:4] !config_error_n)
    else $error("error flag not raised after a failure");
  tdo_edge_a: assert property ($changed(tdo) && tdo_oe |-> !tck)
    else $error("tdo changed while tck was high");
  // =====
  // Pin directions in passive mode and the load stream
  pass_clk_a: assert property (idle_pin(!config_clock_pin_oe))
    else $error("config clock driven in passive mode");
  pass_cs_a: assert property (idle_pin(!mode_select_flash1_cs_n_oe))
    else $error("flash one select driven in passive mode");
  flash2_idle_a: assert property (idle_pin(flash2_select_n))
    else $error("flash two selected in passive mode");
  pass_data_a: assert property (idle_pin(!config_data_lines_oe[0]))
    else $error("data line zero driven in passive mode");
  stream_hold_a: assert property (load_valid && !load_ready |=> load_valid && $stable(load_data))
    else $error("stalled load word not held");
  // Main scenarios reached
  cover property ($rose(user_mode));
  cover property ($fell(config_error_n));
  cover property (load_valid && !load_ready ##1 load_valid && load_ready);
  cover property ($changed(tdo) && tdo_oe);
endmodule
bind config_pin_control config_pin_control_props props (.*);

// >>> tb/config_pin_control_bench.sv
// Self-checking bench for the configuration pin controller
`timescale 1ns/1ps
module config_pin_control_bench;
  import cfg_pin_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic ce, tck, tms, tms_driven, tdi, tdi_driven, external_load_clock;
  logic multi_image_en, dual_quad_en, ext_clk_sel, cascade_en, id_fail, crc_fail, remote_fail;
  logic load_last, tap_load, load_ready, load_valid, active_mode, user_mode;
  logic config_done_flag_in, creset_n, config_clock_pin_in, chip_select_in, test_n;
  logic config_done_flag_oe, tdo, tdo_oe, config_clock_pin_out, config_clock_pin_oe, cascade_select_out;
  logic config_error_n, mode_select_flash1_cs_n_in, mode_select_flash1_cs_n_out, mode_select_flash1_cs_n_oe;
  logic flash2_select_n, h_mode, h_cck, h_hold;
  logic [1:0] image_select, bus_width, image_index;
  logic [DATA_W-1:0] user_io_out, user_io_oe, user_io_in, config_data_lines_in, config_data_lines_out;
  logic [DATA_W-1:0] config_data_lines_oe, load_data, h_data, w;
  int seed = 32'h8327effb;
  int n_mismatch = 0;
  int num_checks = 0;
  logic rnd = 1'h0;
  logic mon = 1'h1;
  logic [31:0] q[$];
  // Clocks: core clock and a free external load clock
  always #2 clk = ~clk;
  always #10 external_load_clock = ~external_load_clock;
  // Pin levels from all enables; done has a pull-up
  assign config_done_flag_in = !config_done_flag_oe && !h_hold;
  assign config_clock_pin_in = config_clock_pin_oe ? config_clock_pin_out : h_cck;
  assign config_data_lines_in = (config_data_lines_oe & config_data_lines_out) | (~config_data_lines_oe & h_data);
  assign mode_select_flash1_cs_n_in = mode_select_flash1_cs_n_oe ? mode_select_flash1_cs_n_out : h_mode;
  config_pin_control dut (.*);
  cfg_host_model host (.creset_n(creset_n), .mode_pin(h_mode), .config_clock_pin(h_cck), .data(h_data), .cs(chip_select_in),
    .test_n(test_n), .done_hold(h_hold));
  // =====
  // Shared tasks
  task check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One test clock period; f leaves TMS floating
  task tick(input logic m, input logic f);
    cyc(1);
    tms = m;
    tms_driven = !f;
    tdi = 1'($random(seed));
    cyc(2);
    tck = 1'h1;
    cyc(12);
    tck = 1'h0;
    cyc(12);
  endtask
  // Word to the host; the model keeps what the buffer and the output stage can hold
  task put(input logic sel);
    w = $random(seed);
    if (sel && q.size() < FIFO_DEPTH + 1) q.push_back(w);
    host.send(w, sel);
  endtask
  // Sink readiness, random while enabled
  always begin
    @(posedge clk);
    #1;
    if (rnd) load_ready = 1'($random(seed));
  end
  // Every word accepted while mon is set against the model
  always @(posedge clk) begin
    if (!rst && mon && load_valid && load_ready) check(load_data, q.size() > 0 ? q.pop_front() : 32'hx);
  end
  // =====
  // Main sequence
  initial begin
    {ce, tck, tms, tms_driven, tdi, tdi_driven, external_load_clock} = 7'h5a;
    {multi_image_en, dual_quad_en, ext_clk_sel, cascade_en, id_fail, crc_fail, remote_fail} = 7'h0;
    {load_last, tap_load, load_ready} = 3'h0;
    image_select = 2'h0;
    bus_width = WIDTH_X32;
    user_io_out = $random(seed);
    user_io_oe = $random(seed);
    cyc(12);
    rst = 1'h0;
    cyc(1);
    check(config_done_flag_oe, 1'h1);
    check(config_error_n, 1'h1);
    check(tdo_oe, 1'h0);
    // Identification register read, left by a floating TMS
    tick(1'h0, 1'h0);
    tick(1'h1, 1'h0);
    tick(1'h0, 1'h0);
    tick(1'h0, 1'h0);
    check(tdo_oe, 1'h1);
    for (int i = 0; i < 32; i++) begin
      check(tdo, ID_CODE[i]);
      tick(1'h0, i == 31);
    end
    check(tdo_oe, 1'h0);
    tick(1'h1, 1'h0);
    tick(1'h0, 1'h0);
    // Passive load: stalled sink fills the buffer, then random drain
    multi_image_en = 1'h1;
    image_select = 2'h2;
    cascade_en = 1'h1;
    host.reconfig(1'h0);
    cyc(40);
    check(active_mode, 1'h0);
    check(config_clock_pin_oe, 1'h0);
    check(config_done_flag_oe, 1'h1);
    host.wait_first();
    put(1'h0);
    for (int i = 0; i < 10; i++) put(1'h1);
    check(load_valid, 1'h1);
    @(posedge clk);
    rnd = 1'h1;
    for (int i = 0; i < 6; i++) put(i[0]);
    @(posedge clk);
    rnd = 1'h0;
    #1 load_ready = 1'h1;
    cyc(40);
    check(q.size(), 0);
    check(load_valid, 1'h0);
    check(image_index, 2'h2);
    // End of load while the host holds done low
    host.hold_done(1'h1);
    cyc(1);
    load_last = 1'h1;
    cyc(1);
    load_last = 1'h0;
    cyc(3);
    check(config_done_flag_oe, 1'h0);
    cyc(20);
    check(user_mode, 1'h0);
    host.hold_done(1'h0);
    cyc(8);
    check(user_mode, 1'h1);
    check(cascade_select_out, 1'h1);
    cyc(4);
    check(config_data_lines_oe, user_io_oe);
    check(user_io_in, (user_io_oe & user_io_out) | (~user_io_oe & h_data));
    // Active loads over every image code and each fault source
    mon = 1'h0;
    dual_quad_en = 1'h1;
    for (int i = 0; i < 4; i++) begin
      image_select = 2'(i);
      cascade_en = i[0];
      host.reconfig(1'h1);
      cyc(40);
      check(active_mode, 1'h1);
      check(config_clock_pin_oe, 1'h1);
      check(mode_select_flash1_cs_n_oe, 1'h1);
      check(mode_select_flash1_cs_n_out, 1'h0);
      check(flash2_select_n, 1'h0);
      check(cascade_select_out, 1'h0);
      check(image_index, i);
      check(config_error_n, 1'h1);
      {id_fail, crc_fail, remote_fail} = 3'h4 >> i;
      cyc(1);
      {id_fail, crc_fail, remote_fail} = 3'h0;
      cyc(4);
      check(config_error_n, i == 3);
    end
    stop_test();
  end
  // Watchdog well beyond the expected run time
  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end
endmodule
